// ===== common/sxp_link_if.sv
/*
 Carrier between the serial link logic (serial clock domain) and the
 register core (mclk domain). Events cross as toggles with held data.
 Assumes the register image only changes well away from a byte load.
*/
`timescale 1ns/1ps
interface sxp_link_if;
    import sxp_pkg::*;
    logic wrTgl;
    logic rdTgl;
    logic refTgl;
    logic [3:0] wrAddr;
    logic [3:0] rdAddr;
    logic [7:0] wrData;
    logic [IMG_W-1:0] image;
    logic [2:0] hwAddr;
    logic linkRst;
    modport link (
        output wrTgl, rdTgl, refTgl, wrAddr, rdAddr, wrData,
        input image, hwAddr, linkRst
    );
    modport core (
        input wrTgl, rdTgl, refTgl, wrAddr, rdAddr, wrData,
        output image, hwAddr, linkRst
    );
endinterface : sxp_link_if

// ===== common/sxp_pkg.sv
/*
 Shared constants of the serial I/O expander port: register indices,
 reset values, control bit positions, opcode layout and link phases.
 Assumes nothing of its surroundings.
*/
package sxp_pkg;
    localparam int REG_COUNT = 11;
    localparam int IMG_W = REG_COUNT * 8;
    localparam int SYNC_W = 13;

    localparam logic [3:0] IDX_DIR = 4'h0;
    localparam logic [3:0] IDX_IPOL = 4'h1;
    localparam logic [3:0] IDX_INTEN = 4'h2;
    localparam logic [3:0] IDX_DEFV = 4'h3;
    localparam logic [3:0] IDX_INTCON = 4'h4;
    localparam logic [3:0] IDX_IOCON = 4'h5;
    localparam logic [3:0] IDX_PULLUP = 4'h6;
    localparam logic [3:0] IDX_INTF = 4'h7;
    localparam logic [3:0] IDX_INTERRUPT_CAPTURE = 4'h8;
    localparam logic [3:0] IDX_GPIO = 4'h9;
    localparam logic [3:0] IDX_OLAT = 4'hA;
    localparam logic [3:0] IDX_LAST = 4'hA;
    localparam logic [3:0] IDX_NONE = 4'hF;

    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;

    localparam int IOC_SEQ_DIS = 5;
    localparam int IOC_ODR = 2;
    localparam int IOC_INTPOL = 1;
    localparam int IOC_INTCC = 0;

    localparam logic [3:0] OPC_FIXED = 4'h4;
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    localparam logic [SYNC_W-1:0] SYNC_RST = 13'h0300;

    typedef enum logic [3:0] {
        PH_OPC = 4'h1,
        PH_ADR = 4'h2,
        PH_DAT = 4'h4,
        PH_IGN = 4'h8
    } sxp_phase_t;

    typedef enum logic [1:0] {
        ST_STRAP = 2'h1,
        ST_RUN = 2'h2
    } sxp_state_t;

    function automatic logic [7:0] regByte(input logic [IMG_W-1:0] img, input logic [3:0] idx);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < REG_COUNT; i++) begin
            if (idx == 4'(i)) begin
                b = img[i*8 +: 8];
            end
        end
        return b;
    endfunction : regByte
endpackage : sxp_pkg

// ===== core/sxp_port.sv
/*
 Eight-pin open-drain I/O expander port with a serial peripheral link.
 Assumes pins are pulled high externally or by the pull-up enables,
 and that the hardware address strap is stable during reset.
*/
// Function
// - Reset makes all pins inputs, undriven
// - Direction bit per pin selects input/output
// - Input port and output latch registers
// - Polarity bit inverts read input value
// - All registers readable by master
// - Per-pin choice: change or compare mode
// - Change mode: input differs from last
// - Compare mode: input differs from default
// - Capture port value at interrupt
// - Reset loads defaults, restarts state machine
// - Interrupt pin: high, low, open-drain
// - Per-pin interrupt enable and pull-up
// - Outputs only pull low or release
// - Address pins form part of slave address
// - Eleven byte registers, capture read-only
// - Sequential pointer increments and wraps
// - Interrupted byte is discarded
// - Sample rising edge, shift falling edge
`timescale 1ns/1ps
module sxp_port
    import sxp_pkg::*;
(
    // Clock, enable and reset
    input wire logic mclk,
    input wire logic clkEn,
    input wire logic sys_rst,
    // Serial link pins
    input wire logic spiSck,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOeN,
    // Straps and hardware reset pin
    input wire logic [2:0] hwAddr,
    input wire logic resetPinN,
    // Port pins
    input wire logic [7:0] portPinIn,
    output logic [7:0] portPinOut,
    output logic [7:0] portPinOeN,
    output logic [7:0] pullUpEn,
    // Interrupt pin
    output logic intPinOut,
    output logic intPinOeN
);
    sxp_link_if lnk ();

    sxp_spi_link uLink (
        .spiSck(spiSck),
        .spiCsN(spiCsN),
        .spiMosi(spiMosi),
        .spiMiso(spiMiso),
        .spiMisoOeN(spiMisoOeN),
        .lk(lnk.link)
    );

    logic [SYNC_W-1:0] syncA_r;
    logic [SYNC_W-1:0] syncB_r;
    logic [SYNC_W-1:0] syncC_r;
    logic [SYNC_W-1:0] filt_r;
    logic [SYNC_W-1:0] syncIn;
    logic [SYNC_W-1:0] agree;
    logic [7:0] pinLvl;
    logic csHigh;
    logic coreRst;
    logic coreRst_r;

    assign syncIn = {hwAddr, resetPinN, spiCsN, portPinIn};
    assign agree = syncB_r ~^ syncC_r;
    assign pinLvl = filt_r[7:0];
    assign csHigh = filt_r[8];
    assign coreRst = sys_rst | ~filt_r[9];

    // The chain keeps sampling through reset, so the strap is settled
    // by the time it is latched after release
    always_ff @(posedge mclk) begin
        if (clkEn) begin
            syncA_r <= syncIn;
            syncB_r <= syncA_r;
            syncC_r <= syncB_r;
        end
    end

    // A pin level is believed only once two later stages agree
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            filt_r <= SYNC_RST;
        end else if (clkEn) begin
            filt_r <= (agree & syncB_r) | (~agree & filt_r);
        end
    end

    always_ff @(posedge mclk) begin
        if (clkEn) begin
            coreRst_r <= coreRst;
        end
    end
    assign lnk.linkRst = coreRst_r;

    logic [2:0] tglA_r;
    logic [2:0] tglB_r;
    logic [2:0] tglC_r;
    logic wrEvt;
    logic rdEvt;
    logic refEvt;

    assign wrEvt = tglB_r[0] ^ tglC_r[0];
    assign rdEvt = tglB_r[1] ^ tglC_r[1];
    assign refEvt = tglB_r[2] ^ tglC_r[2];

    always_ff @(posedge mclk) begin
        if (coreRst) begin
            tglA_r <= 3'h0;
            tglB_r <= 3'h0;
            tglC_r <= 3'h0;
        end else if (clkEn) begin
            tglA_r <= {lnk.refTgl, lnk.rdTgl, lnk.wrTgl};
            tglB_r <= tglA_r;
            tglC_r <= tglB_r;
        end
    end

    sxp_state_t state_r;
    logic [1:0] strapCnt_r;
    logic [2:0] hwAddr_r;

    always_ff @(posedge mclk) begin
        if (coreRst) begin
            state_r <= ST_STRAP;
            strapCnt_r <= 2'h0;
            hwAddr_r <= 3'h0;
        end else if (clkEn) begin
            case (state_r)
                ST_STRAP: begin
                    strapCnt_r <= strapCnt_r + 2'h1;
                    if (strapCnt_r == STRAP_WAIT) begin
                        hwAddr_r <= filt_r[12:10];
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_r <= ST_RUN;
                end
                default: begin
                    state_r <= ST_STRAP;
                end
            endcase
        end
    end
    assign lnk.hwAddr = hwAddr_r;

    logic [7:0] dir_r;
    logic [7:0] ipol_r;
    logic [7:0] inten_r;
    logic [7:0] defv_r;
    logic [7:0] intcon_r;
    logic [7:0] iocon_r;
    logic [7:0] pullup_r;
    logic [7:0] olat_r;
    logic wrOk;

    assign wrOk = wrEvt && (state_r == ST_RUN);

    always_ff @(posedge mclk) begin
        if (coreRst) begin
            dir_r <= RST_DIR;
            ipol_r <= RST_ZERO;
            inten_r <= RST_ZERO;
            defv_r <= RST_ZERO;
            intcon_r <= RST_ZERO;
            iocon_r <= RST_ZERO;
            pullup_r <= RST_ZERO;
            olat_r <= RST_ZERO;
        end else if (clkEn && wrOk) begin
            case (lnk.wrAddr)
                IDX_DIR: dir_r <= lnk.wrData;
                IDX_IPOL: ipol_r <= lnk.wrData;
                IDX_INTEN: inten_r <= lnk.wrData;
                IDX_DEFV: defv_r <= lnk.wrData;
                IDX_INTCON: intcon_r <= lnk.wrData;
                IDX_IOCON: iocon_r <= lnk.wrData;
                IDX_PULLUP: pullup_r <= lnk.wrData;
                IDX_GPIO, IDX_OLAT: olat_r <= lnk.wrData;
                default: olat_r <= olat_r;
            endcase
        end
    end

    logic [7:0] gpio_r;
    logic [7:0] intf_r;
    logic [7:0] interrupt_capture_r;
    logic [7:0] gpio_nxt;
    logic [7:0] chgHit;
    logic [7:0] cmpHit;
    logic [7:0] hit;
    logic [7:0] intfKept;
    logic clrRead;

    assign gpio_nxt = pinLvl ^ ipol_r;
    assign chgHit = gpio_nxt ^ gpio_r;
    assign cmpHit = gpio_nxt ^ defv_r;
    // One mode per pin; enable gates
    assign hit = inten_r & dir_r & ((intcon_r & cmpHit) | (~intcon_r & chgHit));

    // Reading the selected register acknowledges pending flags
    assign clrRead = rdEvt && (lnk.rdAddr == (iocon_r[IOC_INTCC] ? IDX_INTERRUPT_CAPTURE : IDX_GPIO));
    assign intfKept = clrRead ? RST_ZERO : intf_r;

    always_ff @(posedge mclk) begin
        if (coreRst) begin
            gpio_r <= RST_ZERO;
        end else if (clkEn) begin
            gpio_r <= gpio_nxt;
        end
    end

    // New events win over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (coreRst) begin
            intf_r <= RST_ZERO;
            interrupt_capture_r <= RST_ZERO;
        end else if (clkEn && state_r == ST_RUN) begin
            intf_r <= intfKept | hit;
            if (hit != RST_ZERO && intfKept == RST_ZERO) begin
                interrupt_capture_r <= gpio_nxt;
            end
        end
    end

    logic [IMG_W-1:0] image_r;
    logic [IMG_W-1:0] image_nxt;

    assign image_nxt = {olat_r, gpio_r, interrupt_capture_r, intf_r, pullup_r, iocon_r,
                       intcon_r, defv_r, inten_r, ipol_r, dir_r};

    // Read image of all registers
    // Refreshed every cycle while chip select is high and right after a byte load, so the link sees it stable
    always_ff @(posedge mclk) begin
        if (coreRst) begin
            image_r <= {IMG_W{1'b0}};
        end else if (clkEn && (csHigh || refEvt)) begin
            image_r <= image_nxt;
        end
    end
    assign lnk.image = image_r;

    logic intAct;
    assign intAct = |intf_r;
    assign portPinOut = RST_ZERO;

    always_ff @(posedge mclk) begin
        if (coreRst) begin
            portPinOeN <= 8'hFF;
            pullUpEn <= RST_ZERO;
            intPinOut <= 1'b1;
            intPinOeN <= 1'b0;
        end else if (clkEn) begin
            portPinOeN <= dir_r | olat_r;
            pullUpEn <= pullup_r;
            if (iocon_r[IOC_ODR]) begin
                intPinOut <= 1'b0;
                intPinOeN <= ~intAct;
            end else begin
                intPinOut <= ~(intAct ^ iocon_r[IOC_INTPOL]);
                intPinOeN <= 1'b0;
            end
        end
    end
endmodule : sxp_port

// ===== core/sxp_spi_link.sv
/*
 Serial peripheral slave of the expander, clocked by the link clock.
 Frame state is cleared by chip select going high; event toggles are
 cleared only by the core reset so a frame end never fakes an event.
*/
`timescale 1ns/1ps
module sxp_spi_link
    import sxp_pkg::*;
(
    // Link pins
    input wire logic spiSck,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOeN,
    // Core side
    sxp_link_if.link lk
);
    sxp_phase_t phase_r;
    logic [2:0] bitCnt_r;
    logic [6:0] sh_r;
    logic [6:0] osh_r;
    logic isRead_r;
    logic [3:0] ptr_r;
    logic [7:0] rxByte;
    logic [7:0] txByte;
    logic seqDis;
    logic byteEnd;
    logic [7:0] ioconByte;

    assign rxByte = {sh_r, spiMosi};
    assign txByte = regByte(lk.image, ptr_r);
    assign ioconByte = regByte(lk.image, IDX_IOCON);
    assign seqDis = ioconByte[IOC_SEQ_DIS];
    assign byteEnd = (bitCnt_r == 3'h7) && (phase_r == PH_DAT);
    assign spiMisoOeN = ~(~spiCsN & isRead_r & (phase_r == PH_DAT));

    always_ff @(posedge spiSck or posedge spiCsN) begin
        if (spiCsN) begin
            phase_r <= PH_OPC;
            bitCnt_r <= 3'h0;
            sh_r <= 7'h00;
            isRead_r <= 1'b0;
            ptr_r <= IDX_DIR;
        end else begin
            bitCnt_r <= bitCnt_r + 3'h1;
            sh_r <= rxByte[6:0];
            if (bitCnt_r == 3'h7) begin
                case (phase_r)
                    PH_OPC: begin
                        isRead_r <= spiMosi;
                        phase_r <= (sh_r == {OPC_FIXED, lk.hwAddr}) ? PH_ADR : PH_IGN;
                    end
                    PH_ADR: begin
                        ptr_r <= (rxByte <= {4'h0, IDX_LAST}) ? rxByte[3:0] : IDX_NONE;
                        phase_r <= PH_DAT;
                    end
                    PH_DAT: begin
                        if (!seqDis && ptr_r != IDX_NONE) begin
                            ptr_r <= (ptr_r >= IDX_LAST) ? IDX_DIR : ptr_r + 4'h1;
                        end
                    end
                    PH_IGN: begin
                        phase_r <= PH_IGN;
                    end
                    default: begin
                        phase_r <= PH_IGN;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge spiSck or posedge lk.linkRst) begin
        if (lk.linkRst) begin
            lk.wrTgl <= 1'b0;
            lk.rdTgl <= 1'b0;
            lk.wrAddr <= IDX_NONE;
            lk.rdAddr <= IDX_NONE;
            lk.wrData <= 8'h00;
        end else if (byteEnd && !isRead_r) begin
            lk.wrAddr <= ptr_r;
            lk.wrData <= rxByte;
            lk.wrTgl <= ~lk.wrTgl;
        end else if (byteEnd) begin
            lk.rdAddr <= ptr_r;
            lk.rdTgl <= ~lk.rdTgl;
        end
    end

    always_ff @(negedge spiSck or posedge spiCsN) begin
        if (spiCsN) begin
            spiMiso <= 1'b0;
            osh_r <= 7'h00;
        end else if (bitCnt_r == 3'h0 && phase_r == PH_DAT && isRead_r) begin
            spiMiso <= txByte[7];
            osh_r <= txByte[6:0];
        end else begin
            spiMiso <= osh_r[6];
            osh_r <= {osh_r[5:0], 1'b0};
        end
    end

    // Each byte load asks the core for a fresh image for the next one
    always_ff @(negedge spiSck or posedge lk.linkRst) begin
        if (lk.linkRst) begin
            lk.refTgl <= 1'b0;
        end else if (!spiCsN && bitCnt_r == 3'h0 && phase_r == PH_DAT) begin
            lk.refTgl <= ~lk.refTgl;
        end
    end
endmodule : sxp_spi_link

// ===== verification/sxp_host_model.sv
/*
 Host link master model: modes 0,0 and 1,1, 64 ns clock.
 Assumes frames are started from a testbench process.
*/
`timescale 1ns/1ps
module sxp_host_model (
    // Link pins
    output logic spiSck,
    output logic spiCsN,
    output logic spiMosi,
    input wire logic spiMiso,
    input wire logic spiMisoOeN,
    // Read results
    output logic rdValid,
    output logic [7:0] rdByte,
    output logic sawOe
);
    logic idleHigh;

    initial begin
        idleHigh = 0;
        spiSck = 0;
        spiCsN = 1;
        spiMosi = 0;
        rdValid = 0;
        rdByte = 8'h00;
        sawOe = 0;
    end

    // Odd delays offset each frame, but 32 ns half-periods still put some link edges on mclk edges; clock stands still between frames
    task automatic frame(input logic [7:0] b[$], input int lastBits);
        logic [7:0] sh;
        sh = 8'h00;
        // Settle the idle level while deselected, so no stray edge counts
        spiSck = idleHigh;
        #37;
        spiCsN = 0;
        sawOe = 0;
        #37;
        foreach (b[i]) begin
            for (int k = 7; k >= 0; k--) begin
                // last byte may be cut short
                if (i == b.size() - 1 && 7 - k >= lastBits) break;
                spiSck = 0;
                spiMosi = b[i][k];
                #32;
                spiSck = 1;
                sh = {sh[6:0], spiMisoOeN ? ~sh[0] : spiMiso};
                sawOe |= !spiMisoOeN;
                #32;
            end
            if (i >= 2 && b[0][0]) begin
                rdByte = sh;
                rdValid = 1;
                #1 rdValid = 0;
            end
        end
        spiSck = idleHigh;
        #30;
        spiCsN = 1;
        spiMosi = ~spiMosi;
        #200;
    endtask : frame
endmodule : sxp_host_model

// ===== verification/sxp_port_chk.sv
/*
 Concurrent checks on the top-level pins of the expander port.
 Assumes binding to sxp_port with a single mclk domain.
*/
`timescale 1ns/1ps
module sxp_port_chk
    import sxp_pkg::*;
(
    // Clock and resets
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic resetPinN,
    // Link pins
    input wire logic spiCsN,
    input wire logic spiMiso,
    input wire logic spiMisoOeN,
    // Port and interrupt pins
    input wire logic [7:0] portPinOut,
    input wire logic [7:0] portPinOeN,
    input wire logic [7:0] pullUpEn,
    input wire logic intPinOut,
    input wire logic intPinOeN
);
    logic [7:0] quiet_r;

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Pin settings may only move shortly after link traffic or a reset
    always_ff @(posedge mclk) begin
        if (!spiCsN || !resetPinN || sys_rst) begin
            quiet_r <= 8'h00;
        end else if (quiet_r != 8'hFF) begin
            quiet_r <= quiet_r + 8'h01;
        end
    end

    property p_od_low;
        portPinOut == 8'h00;
    endproperty
    a_od_low: assert property (p_od_low) else $error("port drives high");
    property p_rst_pins;
        $fell(sys_rst) |-> portPinOeN == 8'hFF && pullUpEn == 8'h00;
    endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("pins not at reset");
    property p_rst_hold;
        $fell(sys_rst) |-> (portPinOeN == 8'hFF)[*3];
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("pin driven after reset");
    property p_rst_int;
        $fell(sys_rst) |-> intPinOut && !intPinOeN;
    endproperty
    a_rst_int: assert property (p_rst_int) else $error("interrupt pin not idle");
    property p_miso_sel;
        spiCsN |-> spiMisoOeN;
    endproperty
    a_miso_sel: assert property (p_miso_sel) else $error("miso on unselected");
    property p_miso_idle;
        spiCsN |-> !spiMiso;
    endproperty
    a_miso_idle: assert property (p_miso_idle) else $error("miso not low idle");
    property p_int_od;
        intPinOeN |-> !intPinOut;
    endproperty
    a_int_od: assert property (p_int_od) else $error("interrupt level released");
    property p_oe_cause;
        $changed(portPinOeN) |-> quiet_r < 8'h10;
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
    property p_pu_cause;
        $changed(pullUpEn) |-> quiet_r < 8'h10;
    endproperty
    a_pu_cause: assert property (p_pu_cause) else $error("pull-up moved alone");
endmodule : sxp_port_chk

// ===== verification/testbench.sv
/*
 Self-checking bench of the expander port; pin levels resolved here.
 Assumes the checker and host model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", nm, e, a); end end
module testbench
    import sxp_pkg::*;
;
    logic mclk, clkEn, sys_rst, resetPinN, rdValid, sawOe;
    logic spiSck, spiCsN, spiMosi, spiMiso, spiMisoOeN, intPinOut, intPinOeN;
    logic [2:0] hwAddr;
    logic [7:0] pinExt, portPinIn, portPinOut, portPinOeN, pullUpEn, rdByte;
    logic [7:0] opc, ex, p, q, r, d;
    logic [7:0] expQ[$];
    int err_count, num_checks;

    // Open-drain pins: low wherever the port pulls
    assign portPinIn = pinExt & portPinOeN;

    sxp_port DUT (.mclk(mclk), .clkEn(clkEn), .sys_rst(sys_rst), .spiSck(spiSck),
        .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOeN(spiMisoOeN),
        .hwAddr(hwAddr), .resetPinN(resetPinN), .portPinIn(portPinIn),
        .portPinOut(portPinOut), .portPinOeN(portPinOeN), .pullUpEn(pullUpEn),
        .intPinOut(intPinOut), .intPinOeN(intPinOeN));
    sxp_host_model host (.spiSck(spiSck), .spiCsN(spiCsN), .spiMosi(spiMosi),
        .spiMiso(spiMiso), .spiMisoOeN(spiMisoOeN), .rdValid(rdValid),
        .rdByte(rdByte), .sawOe(sawOe));

    always #10 mclk = ~mclk;

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] v[$]);
        logic [7:0] b[$];
        b = {opc, a, v};
        host.frame(b, 8);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] v[$]);
        logic [7:0] b[$];
        b = {opc | 8'h01, a, v};
        foreach (v[i]) expQ.push_back(v[i]);
        host.frame(b, 8);
    endtask : rd
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run

    always @(posedge rdValid) begin
        if (expQ.size() > 0) begin
            ex = expQ.pop_front();
            `CHK("rdByte", ex, rdByte)
        end
    end

    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        $display("[ERR] run exp done got hang");
        complete_run();
    end

    initial begin
        mclk = 0;
        clkEn = 1;
        sys_rst = 1;
        resetPinN = 1;
        pinExt = 8'hFF;
        void'($urandom(57545));
        hwAddr = 3'($urandom);
        opc = {OPC_FIXED, hwAddr, 1'b0};
        r = 8'($urandom);
        d = 8'($urandom);
        p = 8'($urandom);
        q = 8'($urandom);
        cyc(5);
        sys_rst = 0;
        cyc(15);
        `CHK("oeN", 8'hFF, portPinOeN)
        `CHK("pullUp", 8'h00, pullUpEn)
        rd(8'h00, {8'hFF, 8'h00});
        `CHK("misoOe", 1'b1, sawOe)
        $display("test reset done");
        // host sets direction, pointer wraps to 00
        wr(8'h0A, {r, d});
        wr(8'h06, {q});
        cyc(12);
        `CHK("oeN", d | r, portPinOeN)
        `CHK("pullUp", q, pullUpEn)
        rd(8'h0A, {r, d});
        $display("test latch done");
        wr(8'h00, {8'hFF, q});
        pinExt = p;
        cyc(12);
        `CHK("oeN", 8'hFF, portPinOeN)
        rd(8'h09, {p ^ q, r});
        wr(8'h05, {8'h20});
        rd(8'h01, {q, q});
        wr(8'h05, {8'h00});
        wr(8'h08, {8'hFF});
        rd(8'h08, {8'h00});
        host.frame({opc, 8'h0A, 8'h33}, 4);
        rd(8'h0A, {r});
        host.frame({opc ^ 8'h03, 8'h0A, 8'h00}, 8);
        `CHK("misoOe", 1'b0, sawOe)
        host.idleHigh = 1;
        rd(8'h0A, {r});
        host.idleHigh = 0;
        $display("test link done");
        wr(8'h01, {8'h00, 8'hFF});
        cyc(12);
        `CHK("int", 1'b1, intPinOut)
        pinExt = p ^ 8'h10;
        cyc(12);
        `CHK("int", 1'b0, intPinOut)
        rd(8'h07, {8'h10, p ^ 8'h10, p ^ 8'h10});
        cyc(12);
        `CHK("int", 1'b1, intPinOut)
        wr(8'h03, {p ^ 8'h10, 8'hFF, 8'h04});
        cyc(12);
        `CHK("intOe", 1'b1, intPinOeN)
        pinExt = p ^ 8'h90;
        cyc(12);
        `CHK("intOe", 1'b0, intPinOeN)
        wr(8'h05, {8'h02});
        cyc(12);
        `CHK("int", 1'b1, intPinOut)
        // Capture read acknowledges once the capture-clear option is set
        wr(8'h03, {p ^ 8'h90, 8'h00, 8'h03});
        cyc(12);
        `CHK("int", 1'b1, intPinOut)
        rd(8'h08, {p ^ 8'h90});
        cyc(12);
        `CHK("int", 1'b0, intPinOut)
        // Clock enable low freezes the pin filter, so no change is seen
        clkEn = 0;
        pinExt = p;
        cyc(12);
        `CHK("int", 1'b0, intPinOut)
        clkEn = 1;
        cyc(12);
        `CHK("int", 1'b1, intPinOut)
        $display("test interrupt done");
        resetPinN = 0;
        cyc(10);
        resetPinN = 1;
        cyc(20);
        `CHK("oeN", 8'hFF, portPinOeN)
        rd(8'h05, {8'h00});
        wr(8'h0A, {8'h00, 8'h00});
        cyc(12);
        `CHK("oeN", 8'h00, portPinOeN)
        sys_rst = 1;
        cyc(2);
        sys_rst = 0;
        cyc(20);
        `CHK("oeN", 8'hFF, portPinOeN)
        $display("test reset pin done");
        `CHK("unread", 0, expQ.size())
        complete_run();
    end
endmodule : testbench

bind sxp_port sxp_port_chk u_chk (.mclk(mclk), .sys_rst(sys_rst),
    .resetPinN(resetPinN), .spiCsN(spiCsN), .spiMiso(spiMiso),
    .spiMisoOeN(spiMisoOeN), .portPinOut(portPinOut), .portPinOeN(portPinOeN),
    .pullUpEn(pullUpEn), .intPinOut(intPinOut), .intPinOeN(intPinOeN));
